// file: rtl/gocd_defines.vh
// Constants for the global output configuration decoder.
// Operation
// - Drive select applies only in lock-indicator source.
// - Select 0: push-pull, high while unlocked.
// - Select 1: open drain, low while unlocked.
// - Clock source on aux pin ignores drive select.
// - Unlock gating 0: clock outputs held low while unlocked.
// - Unlock gating 1: clock outputs enabled while unlocked too.
// - Format 0 reads ratio as 20.12.
// - Format 1 reads ratio as 12.20.
// - Maps 000/001/010 gate clock, aux, both.
// - Map 011: pin enables manual ratio shift.
// - Map 101: pin overrides auto ratio shift.
// - Map 111: pin forces aux source 10.
// - Bandwidth code doubles from 1 Hz upward.
// - Disable mappings: pin low enables, high disables.
// - Shift mapping: pin high enables, only means.
// - Override mapping: pin low follows modal source.
`ifndef GOCD_DEFINES_VH
`define GOCD_DEFINES_VH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define GOCD_ADDR_CONFIG 8'h00
`define GOCD_ADDR_STATUS 8'h04
`define GOCD_ADDR_IRQ_STATUS 8'h08
`define GOCD_ADDR_IRQ_MASK 8'h0C
`define GOCD_ADDR_RATIO_INT 8'h10
`define GOCD_ADDR_RATIO_FRAC 8'h14
`define GOCD_ADDR_BANDWIDTH 8'h18

// -----------------------------------------------------------------
// Configuration fields
// -----------------------------------------------------------------
`define GOCD_CFG_DRIVE_BIT 0
`define GOCD_CFG_UNLOCK_BIT 1
`define GOCD_CFG_FORMAT_BIT 2
`define GOCD_CFG_MAP_LSB 4
`define GOCD_CFG_MAP_MSB 6
`define GOCD_CFG_BW_LSB 8
`define GOCD_CFG_BW_MSB 10
`define GOCD_CFG_RESET 11'h000

// -----------------------------------------------------------------
// Interrupt bits
// -----------------------------------------------------------------
`define GOCD_IRQ_LOCK_LOST 0
`define GOCD_IRQ_LOCK_GAINED 1
`define GOCD_IRQ_PIN_CHANGE 2
`define GOCD_IRQ_RESET 3'h0

// -----------------------------------------------------------------
// Codes
// -----------------------------------------------------------------
`define GOCD_SRC_RESERVED 2'h0
`define GOCD_SRC_REF_CLK 2'h1
`define GOCD_SRC_PLL_CLK 2'h2
`define GOCD_SRC_LOCK_IND 2'h3
`define GOCD_MAP_DIS_CLK 3'h0
`define GOCD_MAP_DIS_AUX 3'h1
`define GOCD_MAP_DIS_BOTH 3'h2
`define GOCD_MAP_SHIFT_EN 3'h3
`define GOCD_MAP_AUTO_OVR 3'h5
`define GOCD_MAP_SRC_OVR 3'h7

`endif

// file: rtl/gocd_sync3.v
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module gocd_sync3 #(
    parameter RESET_VALUE = 1'b0
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Asynchronous input
    input wire async_in,
    // Filtered synchronous level
    output wire level_out
);

    reg stage1_reg;
    reg stage2_reg;
    reg stage3_reg;
    reg level_reg;

    // The first stage feeds only the second stage, so metastability
    // never reaches the agreement compare.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= RESET_VALUE;
            stage2_reg <= RESET_VALUE;
            stage3_reg <= RESET_VALUE;
            level_reg <= RESET_VALUE;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            if (stage2_reg == stage3_reg) begin
                level_reg <= stage3_reg;
            end
        end
    end

    assign level_out = level_reg;

endmodule

// file: rtl/gocd_global_output_config.v
// Global output configuration decoder with register port.
`timescale 1ns/1ps
`include "gocd_defines.vh"
module gocd_global_output_config (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [31:0] reg_rdata,
    // Interrupt
    output wire irq,
    // PLL status and clocks
    input wire pll_locked,
    input wire pll_clk_in,
    input wire ref_clk_in,
    // Mode pin
    input wire third_mode_pin,
    // Modal parameters chosen by the other mode pins
    input wire [1:0] aux_pin_source_select,
    input wire [1:0] ratio_shift_select,
    input wire auto_ratio_shift_enable,
    input wire [31:0] user_ratio,
    // Clock pins
    output wire pll_clock_pin,
    output wire aux_pin_o,
    output wire aux_pin_oe,
    // Decoded settings
    output wire [1:0] aux_source_eff,
    output wire ratio_shift_enable,
    output wire [2:0] ratio_shift_amount,
    output wire auto_ratio_shift_eff,
    output wire [19:0] ratio_int,
    output wire [19:0] ratio_frac,
    output wire [7:0] min_bandwidth_hz
);

    // -----------------------------------------------------------------
    // Reset release
    // -----------------------------------------------------------------
    reg rst_meta_reg;
    reg rst_sync_reg;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    wire rst_int_n;
    assign rst_int_n = rst_sync_reg;

    // -----------------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------------
    wire locked_sync;
    wire pin_sync;

    gocd_sync3 #(
        .RESET_VALUE(1'b0)
    ) u_sync_lock (
        .clk_sys(clk_sys),
        .rst_n(rst_int_n),
        .async_in(pll_locked),
        .level_out(locked_sync)
    );

    gocd_sync3 #(
        .RESET_VALUE(1'b0)
    ) u_sync_pin (
        .clk_sys(clk_sys),
        .rst_n(rst_int_n),
        .async_in(third_mode_pin),
        .level_out(pin_sync)
    );

    // -----------------------------------------------------------------
    // Configuration register
    // -----------------------------------------------------------------
    reg [10:0] config_reg;
    reg [2:0] irq_status_reg;
    reg [2:0] irq_mask_reg;

    wire wr_config;
    wire wr_irq_status;
    wire wr_irq_mask;
    assign wr_config = reg_wr && (reg_addr == `GOCD_ADDR_CONFIG);
    assign wr_irq_status = reg_wr && (reg_addr == `GOCD_ADDR_IRQ_STATUS);
    assign wr_irq_mask = reg_wr && (reg_addr == `GOCD_ADDR_IRQ_MASK);

    always @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            config_reg <= `GOCD_CFG_RESET;
        end else if (wr_config) begin
            config_reg <= reg_wdata[10:0];
        end
    end

    wire unlock_pin_drive_select;
    wire output_during_unlock;
    wire ratio_format_select;
    wire [2:0] third_pin_function_map;
    wire [2:0] ref_min_loop_bandwidth;
    assign unlock_pin_drive_select = config_reg[`GOCD_CFG_DRIVE_BIT];
    assign output_during_unlock = config_reg[`GOCD_CFG_UNLOCK_BIT];
    assign ratio_format_select = config_reg[`GOCD_CFG_FORMAT_BIT];
    assign third_pin_function_map =
        config_reg[`GOCD_CFG_MAP_MSB:`GOCD_CFG_MAP_LSB];
    assign ref_min_loop_bandwidth =
        config_reg[`GOCD_CFG_BW_MSB:`GOCD_CFG_BW_LSB];

    // -----------------------------------------------------------------
    // Third pin decode
    // -----------------------------------------------------------------
    reg clk_disable_next;
    reg aux_disable_next;
    reg shift_en_next;
    reg auto_next;
    reg [1:0] src_next;

    always @* begin
        clk_disable_next = 1'b0;
        aux_disable_next = 1'b0;
        shift_en_next = 1'b0;
        auto_next = auto_ratio_shift_enable;
        src_next = aux_pin_source_select;
        case (third_pin_function_map)
            `GOCD_MAP_DIS_CLK: begin
                clk_disable_next = pin_sync;
            end
            `GOCD_MAP_DIS_AUX: begin
                aux_disable_next = pin_sync;
            end
            `GOCD_MAP_DIS_BOTH: begin
                clk_disable_next = pin_sync;
                aux_disable_next = pin_sync;
            end
            `GOCD_MAP_SHIFT_EN: begin
                shift_en_next = pin_sync;
            end
            `GOCD_MAP_AUTO_OVR: begin
                auto_next = pin_sync;
            end
            `GOCD_MAP_SRC_OVR: begin
                if (pin_sync) begin
                    src_next = `GOCD_SRC_PLL_CLK;
                end
            end
            default: begin
                // Reserved maps leave every modal setting as it is.
                src_next = aux_pin_source_select;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // Decoded setting registers
    // -----------------------------------------------------------------
    reg clk_disable_reg;
    reg aux_disable_reg;
    reg shift_en_reg;
    reg auto_reg;
    reg [1:0] src_reg;
    reg [2:0] shift_amount_reg;
    reg [19:0] ratio_int_reg;
    reg [19:0] ratio_frac_reg;
    reg [7:0] bandwidth_reg;
    reg clk_en_reg;
    reg aux_clk_en_reg;

    wire clocks_allowed;
    assign clocks_allowed = output_during_unlock | locked_sync;

    always @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            clk_disable_reg <= 1'b0;
            aux_disable_reg <= 1'b0;
            shift_en_reg <= 1'b0;
            auto_reg <= 1'b0;
            src_reg <= `GOCD_SRC_RESERVED;
            shift_amount_reg <= 3'h1;
            ratio_int_reg <= 20'h00000;
            ratio_frac_reg <= 20'h00000;
            bandwidth_reg <= 8'h01;
            clk_en_reg <= 1'b0;
            aux_clk_en_reg <= 1'b0;
        end else begin
            clk_disable_reg <= clk_disable_next;
            aux_disable_reg <= aux_disable_next;
            shift_en_reg <= shift_en_next;
            auto_reg <= auto_next;
            src_reg <= src_next;
            shift_amount_reg <= {1'b0, ratio_shift_select} + 3'h1;
            if (ratio_format_select) begin
                ratio_int_reg <= {8'h00, user_ratio[31:20]};
                ratio_frac_reg <= user_ratio[19:0];
            end else begin
                ratio_int_reg <= user_ratio[31:12];
                ratio_frac_reg <= {user_ratio[11:0], 8'h00};
            end
            bandwidth_reg <= 8'h01 << ref_min_loop_bandwidth;
            clk_en_reg <= clocks_allowed & ~clk_disable_next;
            aux_clk_en_reg <= clocks_allowed & ~aux_disable_next;
        end
    end

    // -----------------------------------------------------------------
    // Clock pin gating
    // -----------------------------------------------------------------
    // The gate is a plain AND with a registered enable; the enable can
    // change mid-period, so a short pulse is possible on a change.
    assign pll_clock_pin = pll_clk_in & clk_en_reg;

    // -----------------------------------------------------------------
    // Auxiliary pin
    // -----------------------------------------------------------------
    reg aux_o_next;
    reg aux_oe_next;

    always @* begin
        aux_o_next = 1'b0;
        aux_oe_next = 1'b1;
        case (src_reg)
            `GOCD_SRC_REF_CLK: begin
                aux_o_next = ref_clk_in & aux_clk_en_reg;
            end
            `GOCD_SRC_PLL_CLK: begin
                aux_o_next = pll_clk_in & aux_clk_en_reg;
            end
            `GOCD_SRC_LOCK_IND: begin
                if (aux_disable_reg) begin
                    aux_o_next = 1'b0;
                    aux_oe_next = ~unlock_pin_drive_select;
                end else if (unlock_pin_drive_select) begin
                    aux_o_next = 1'b0;
                    aux_oe_next = ~locked_sync;
                end else begin
                    aux_o_next = ~locked_sync;
                    aux_oe_next = 1'b1;
                end
            end
            default: begin
                aux_o_next = 1'b0;
                aux_oe_next = 1'b1;
            end
        endcase
    end

    assign aux_pin_o = aux_o_next;
    assign aux_pin_oe = aux_oe_next;

    // -----------------------------------------------------------------
    // Interrupt status
    // -----------------------------------------------------------------
    reg locked_prev_reg;
    reg pin_prev_reg;

    always @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            locked_prev_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            locked_prev_reg <= locked_sync;
            pin_prev_reg <= pin_sync;
        end
    end

    wire [2:0] irq_event;
    assign irq_event[`GOCD_IRQ_LOCK_LOST] = locked_prev_reg & ~locked_sync;
    assign irq_event[`GOCD_IRQ_LOCK_GAINED] = ~locked_prev_reg & locked_sync;
    assign irq_event[`GOCD_IRQ_PIN_CHANGE] = pin_prev_reg ^ pin_sync;

    // A new event in the clearing cycle wins, so no event is lost.
    always @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            irq_status_reg <= `GOCD_IRQ_RESET;
        end else if (wr_irq_status) begin
            irq_status_reg <= (irq_status_reg & ~reg_wdata[2:0]) | irq_event;
        end else begin
            irq_status_reg <= irq_status_reg | irq_event;
        end
    end

    always @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            irq_mask_reg <= `GOCD_IRQ_RESET;
        end else if (wr_irq_mask) begin
            irq_mask_reg <= reg_wdata[2:0];
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // -----------------------------------------------------------------
    // Read port
    // -----------------------------------------------------------------
    reg [31:0] rd_next;
    reg [31:0] rdata_reg;

    always @* begin
        rd_next = 32'h00000000;
        case (reg_addr)
            `GOCD_ADDR_CONFIG: begin
                rd_next = {21'h000000, config_reg};
            end
            `GOCD_ADDR_STATUS: begin
                rd_next = {24'h000000, auto_reg, shift_en_reg,
                           aux_clk_en_reg, clk_en_reg, src_reg,
                           pin_sync, locked_sync};
            end
            `GOCD_ADDR_IRQ_STATUS: begin
                rd_next = {29'h00000000, irq_status_reg};
            end
            `GOCD_ADDR_IRQ_MASK: begin
                rd_next = {29'h00000000, irq_mask_reg};
            end
            `GOCD_ADDR_RATIO_INT: begin
                rd_next = {12'h000, ratio_int_reg};
            end
            `GOCD_ADDR_RATIO_FRAC: begin
                rd_next = {12'h000, ratio_frac_reg};
            end
            `GOCD_ADDR_BANDWIDTH: begin
                rd_next = {24'h000000, bandwidth_reg};
            end
            default: begin
                rd_next = 32'h00000000;
            end
        endcase
    end

    // Data stand only in the cycle after the read strobe.
    always @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            rdata_reg <= 32'h00000000;
        end else if (reg_rd) begin
            rdata_reg <= rd_next;
        end else begin
            rdata_reg <= 32'h00000000;
        end
    end

    assign reg_rdata = rdata_reg;

    // -----------------------------------------------------------------
    // Decoded outputs
    // -----------------------------------------------------------------
    assign aux_source_eff = src_reg;
    assign ratio_shift_enable = shift_en_reg;
    assign ratio_shift_amount = shift_amount_reg;
    assign auto_ratio_shift_eff = auto_reg;
    assign ratio_int = ratio_int_reg;
    assign ratio_frac = ratio_frac_reg;
    assign min_bandwidth_hz = bandwidth_reg;

endmodule

// file: tb/gocd_checker.sv
// Concurrent checks on the ports of the configuration decoder.
`timescale 1ns/1ps
`include "gocd_defines.vh"
module gocd_checker (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // Pins and modal inputs
    input wire pll_locked,
    input wire [1:0] aux_pin_source_select,
    input wire auto_ratio_shift_enable,
    input wire [31:0] user_ratio,
    input wire pll_clock_pin,
    input wire aux_pin_o,
    input wire aux_pin_oe,
    // Decoded settings
    input wire [1:0] aux_source_eff,
    input wire ratio_shift_enable,
    input wire auto_ratio_shift_eff,
    input wire [19:0] ratio_int,
    input wire [19:0] ratio_frac,
    input wire [7:0] min_bandwidth_hz
);
    // ------------------------------------------------------------
    // Shadow state
    // ------------------------------------------------------------
    reg [10:0] cfg_reg;
    reg [10:0] cfg_d_reg;
    reg [31:0] ratio_d_reg;
    reg [1:0] src_d_reg;
    reg auto_d_reg;
    reg [2:0] up_reg;
    reg [3:0] unl_reg;
    wire ready = up_reg == 3'h7;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= 11'h000;
            cfg_d_reg <= 11'h000;
            ratio_d_reg <= 32'h0;
            src_d_reg <= 2'h0;
            auto_d_reg <= 1'h0;
            up_reg <= 3'h0;
            unl_reg <= 4'h0;
        end else begin
            if (reg_wr && reg_addr == `GOCD_ADDR_CONFIG) begin
                cfg_reg <= reg_wdata[10:0];
            end
            cfg_d_reg <= cfg_reg;
            ratio_d_reg <= user_ratio;
            src_d_reg <= aux_pin_source_select;
            auto_d_reg <= auto_ratio_shift_enable;
            up_reg <= ready ? up_reg : up_reg + 3'h1;
            unl_reg <= pll_locked ? 4'h0 : unl_reg + {3'h0, unl_reg != 4'hF};
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_long_unlock;
        ready && unl_reg == 4'hF && !cfg_reg[1] && !cfg_d_reg[1];
    endsequence
    chk_rdata_idle:
        assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside slot");
    chk_bw_decode:
        assert property (ready |->
            min_bandwidth_hz == 8'h01 << cfg_d_reg[10:8])
        else $error("bandwidth decode wrong");
    chk_fmt_wide_int:
        assert property (ready && !cfg_d_reg[2] |-> ratio_int ==
            ratio_d_reg[31:12] && ratio_frac == {ratio_d_reg[11:0], 8'h00})
        else $error("format 0 split wrong");
    chk_fmt_wide_frac:
        assert property (ready && cfg_d_reg[2] |-> ratio_int ==
            {8'h00, ratio_d_reg[31:20]} && ratio_frac == ratio_d_reg[19:0])
        else $error("format 1 split wrong");
    chk_shift_gate:
        assert property (ready && ratio_shift_enable |->
            cfg_d_reg[6:4] == 3'h3)
        else $error("shift enabled outside map");
    chk_auto_keep:
        assert property (ready && cfg_d_reg[6:4] != 3'h5 |->
            auto_ratio_shift_eff == auto_d_reg)
        else $error("auto shift altered");
    chk_src_override:
        assert property (ready && aux_source_eff != src_d_reg |->
            cfg_d_reg[6:4] == 3'h7 && aux_source_eff == 2'h2)
        else $error("aux source altered");
    chk_push_pull:
        assert property (ready && aux_source_eff == 2'h3 && !cfg_reg[0] &&
            !cfg_d_reg[0] |-> aux_pin_oe)
        else $error("push-pull not driving");
    chk_open_drain:
        assert property (ready && aux_source_eff == 2'h3 && cfg_reg[0] &&
            cfg_d_reg[0] |-> !(aux_pin_oe && aux_pin_o))
        else $error("open drain drove high");
    chk_clock_drive:
        assert property (ready && aux_source_eff[1] != aux_source_eff[0] |->
            aux_pin_oe)
        else $error("aux clock not driven");
    chk_unlock_low:
        assert property (s_long_unlock |-> !pll_clock_pin)
        else $error("clock active unlocked");
endmodule
bind gocd_global_output_config gocd_checker u_chk (.*);

// file: tb/gocd_board_model.sv
// Board-side model: free-running clocks and the pulled-up aux line.
`timescale 1ns/1ps
module gocd_board_model (
    // Clocks toward the device
    output reg pll_clk_in,
    output reg ref_clk_in,
    // Auxiliary pin from the device
    input wire aux_pin_o,
    input wire aux_pin_oe,
    // Level seen on the board
    output wire aux_line
);
    // Fractional offsets keep these edges clear of bench samples.
    initial begin
        pll_clk_in = 1'h0;
        #0.3;
        forever #65 pll_clk_in = ~pll_clk_in;
    end
    initial begin
        ref_clk_in = 1'h0;
        #0.7;
        forever #85 ref_clk_in = ~ref_clk_in;
    end
    // The pull-up lifts the line once the open drain lets go.
    assign aux_line = aux_pin_oe ? aux_pin_o : 1'h1;
endmodule

// file: tb/tb.sv
// Self-checking bench for the configuration decoder.
`timescale 1ns/1ps
`include "gocd_defines.vh"
module tb;
    reg clk_sys = 1'h0;
    reg rst_n = 1'h0;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'h0;
    reg reg_rd = 1'h0;
    reg pll_locked = 1'h0;
    reg third_mode_pin = 1'h0;
    reg [1:0] aux_pin_source_select = 2'h1;
    reg [1:0] ratio_shift_select = 2'h2;
    reg auto_ratio_shift_enable = 1'h1;
    reg [31:0] user_ratio = 32'h0013A92A;
    wire [31:0] reg_rdata;
    wire [19:0] ratio_int, ratio_frac;
    wire [7:0] min_bandwidth_hz;
    wire [2:0] ratio_shift_amount;
    wire [1:0] aux_source_eff;
    wire irq, pll_clk_in, ref_clk_in, pll_clock_pin, aux_pin_o, aux_pin_oe;
    wire aux_line, ratio_shift_enable, auto_ratio_shift_eff;
    integer failures, num_checks, i, k;
    integer cycles = 0;
    reg [31:0] d;
    reg eb;
    wire [31:0] dec = {24'h0, auto_ratio_shift_eff, ratio_shift_enable,
        2'h0, aux_source_eff, 2'h0};
    gocd_global_output_config uut (.*);
    gocd_board_model board (.pll_clk_in(pll_clk_in), .ref_clk_in(ref_clk_in),
        .aux_pin_o(aux_pin_o), .aux_pin_oe(aux_pin_oe), .aux_line(aux_line));
    // ------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    // The whole sequence needs some 700 cycles.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            stop_test;
        end
    end
    task stop_test;
        begin
            $display("checks %0d failures %0d", num_checks, failures);
            if (failures == 0 && num_checks > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    task chk(input string n, input [31:0] e, input [31:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("[ERR] %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_wdata <= v;
            reg_wr <= 1'h1;
            @(posedge clk_sys);
            reg_wr <= 1'h0;
        end
    endtask
    task rchk(input [7:0] a, input [31:0] e, input string n);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_rd <= 1'h1;
            @(posedge clk_sys);
            reg_rd <= 1'h0;
            #1;
            chk(n, e, reg_rdata);
        end
    endtask
    // Pin and lock pass a synchroniser, so let them settle.
    task pins(input lk, input p);
        begin
            @(posedge clk_sys);
            pll_locked <= lk;
            third_mode_pin <= p;
            repeat (16) @(posedge clk_sys);
            #1;
        end
    endtask
    task clk_cmp(input em, input ea, input from_pll);
        begin
            for (k = 0; k < 6; k = k + 1) begin
                #37;
                eb = em & pll_clk_in;
                chk("clk_pin", {31'h0, eb}, {31'h0, pll_clock_pin});
                eb = ea & (from_pll ? pll_clk_in : ref_clk_in);
                chk("aux_clk", {31'h0, eb}, {31'h0, aux_pin_o});
            end
        end
    endtask
    function [31:0] cfg(input dr, input un, input fm, input [2:0] mp,
        input [2:0] bw);
        begin
            cfg = {21'h0, bw, 1'h0, mp, 1'h0, fm, un, dr};
        end
    endfunction
    function [31:0] mexp(input [2:0] m, input p);
        begin
            mexp = {30'h0, p, 1'h1};
            mexp[3:2] = (p && m == 3'h7) ? 2'h2 : 2'h1;
            mexp[4] = !(p && (m == 3'h0 || m == 3'h2));
            mexp[5] = !(p && (m == 3'h1 || m == 3'h2));
            mexp[6] = p && m == 3'h3;
            mexp[7] = (m == 3'h5) ? p : 1'h1;
        end
    endfunction
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        failures = 0;
        num_checks = 0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk_sys);
        rchk(`GOCD_ADDR_CONFIG, 32'h0, "config");
        rchk(`GOCD_ADDR_IRQ_MASK, 32'h0, "irq_mask");
        wr(`GOCD_ADDR_RATIO_INT, 32'hFFFFFFFF);
        rchk(`GOCD_ADDR_RATIO_INT, 32'h13A, "ratio_ro");
        rchk(8'h1C, 32'h0, "unmapped");
        pins(1'h0, 1'h0);
        clk_cmp(1'h0, 1'h0, 1'h0);
        $display("test reset done");
        for (i = 0; i < 8; i = i + 1) begin
            wr(`GOCD_ADDR_CONFIG, cfg(1'h0, 1'h1, 1'h0, 3'h4, i[2:0]));
            rchk(`GOCD_ADDR_BANDWIDTH, 32'h1 << i, "bw_reg");
            chk("bw_port", 32'h1 << i, {24'h0, min_bandwidth_hz});
        end
        $display("test bandwidth done");
        pins(1'h1, 1'h0);
        clk_cmp(1'h1, 1'h1, 1'h0);
        for (i = 0; i < 2; i = i + 1) begin
            wr(`GOCD_ADDR_CONFIG, cfg(1'h0, 1'h1, i[0], 3'h4, 3'h0));
            pins(1'h1, 1'h0);
            d = i ? 32'h1 : 32'h13A;
            chk("ratio_int", d, {12'h0, ratio_int});
            d = i ? 32'h3A92A : 32'h92A00;
            chk("ratio_frac", d, {12'h0, ratio_frac});
        end
        $display("test ratio done");
        aux_pin_source_select <= 2'h3;
        for (i = 0; i < 4; i = i + 1) begin
            wr(`GOCD_ADDR_CONFIG, cfg(i[1], 1'h1, 1'h0, 3'h4, 3'h0));
            pins(i[0], 1'h0);
            chk("aux_oe", {31'h0, ~(i[1] & i[0])}, {31'h0, aux_pin_oe});
            eb = i[1] ? i[0] : ~i[0];
            chk("aux_line", {31'h0, eb}, {31'h0, aux_line});
        end
        aux_pin_source_select <= 2'h2;
        for (i = 0; i < 2; i = i + 1) begin
            wr(`GOCD_ADDR_CONFIG, cfg(i[0], 1'h1, 1'h0, 3'h4, 3'h0));
            pins(1'h0, 1'h0);
            chk("aux_clk_oe", 32'h1, {31'h0, aux_pin_oe});
            clk_cmp(1'h1, 1'h1, 1'h1);
        end
        wr(`GOCD_ADDR_CONFIG, cfg(1'h1, 1'h0, 1'h0, 3'h4, 3'h0));
        pins(1'h0, 1'h0);
        clk_cmp(1'h0, 1'h0, 1'h1);
        $display("test aux pin done");
        aux_pin_source_select <= 2'h1;
        for (i = 0; i < 16; i = i + 1) begin
            wr(`GOCD_ADDR_CONFIG, cfg(1'h0, 1'h0, 1'h0, i[3:1], 3'h0));
            pins(1'h1, i[0]);
            d = mexp(i[3:1], i[0]);
            rchk(`GOCD_ADDR_STATUS, d, "status");
            chk("map", d & 32'hCC, dec);
        end
        chk("shift_amt", 32'h3, {29'h0, ratio_shift_amount});
        $display("test pin map done");
        wr(`GOCD_ADDR_IRQ_STATUS, 32'h7);
        wr(`GOCD_ADDR_IRQ_MASK, 32'h1);
        pins(1'h0, 1'h0);
        chk("irq_on", 32'h1, {31'h0, irq});
        rchk(`GOCD_ADDR_IRQ_STATUS, 32'h5, "irq_lost");
        wr(`GOCD_ADDR_IRQ_MASK, 32'h0);
        @(negedge clk_sys);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(`GOCD_ADDR_IRQ_STATUS, 32'h1);
        rchk(`GOCD_ADDR_IRQ_STATUS, 32'h4, "irq_clear");
        pins(1'h1, 1'h0);
        wr(`GOCD_ADDR_IRQ_MASK, 32'h2);
        @(negedge clk_sys);
        chk("irq_gain", 32'h1, {31'h0, irq});
        rchk(`GOCD_ADDR_IRQ_STATUS, 32'h6, "irq_gained");
        $display("test interrupt done");
        stop_test;
    end
endmodule
